// *** design/autoneg_consts.svh ***
`ifndef AUTONEG_CONSTS_SVH
`define AUTONEG_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_LOCAL_ABILITY_ADVERT      5'h04
`define IDX_PARTNER_BASE_ABILITY      5'h05
`define IDX_NEGOTIATION_EXPANSION     5'h06
`define IDX_OUTGOING_NEXT_PAGE        5'h07

// local advertisement fields
`define ADV_TEN_BIT                   5
`define ADV_SEL_RESET                 5'h01

// partner base ability: bit 12 is reserved and masked
`define PARTNER_RX_MASK               16'hEFFF
`define PARTNER_RESET                 16'h0000
`define PAGE_MORE_BIT                 15

// expansion status constants
`define EXP_RESERVED                  9'h000
`define EXP_LOC_SPECIFIED             1'b1
`define EXP_LOC_SELECT                1'b1
`define EXP_LOCAL_MORE_CAPABLE        1'b1

// outgoing next page fields
`define NP_MORE_BIT                   15
`define NP_MSG_BIT                    13
`define NP_COMPLY_BIT                 12
`define NP_MORE_RESET                 1'b0
`define NP_MSG_RESET                  1'b1
`define NP_COMPLY_RESET               1'b0
`define NP_CODE_RESET                 11'h001

// strap sampling: cycles of settle after reset release
`define STRAP_SETTLE                  2'h3

`endif

// *** design/autoneg_pkg.sv ***
package autoneg_pkg;

	// whole register state of the block
	typedef struct packed {
		logic [2:0]  strap_sync;
		logic [1:0]  strap_cnt;
		logic        strap_done;
		logic        adv_ten;
		logic [4:0]  adv_sel;
		logic [15:0] partner_word;
		logic        pd_fault;
		logic        partner_np_cap;
		logic        page_rx;
		logic        partner_an_cap;
		logic        np_more;
		logic        np_ack;
		logic        np_msg;
		logic        np_comply;
		logic        np_toggle;
		logic [10:0] np_code;
		logic [15:0] rdata;
		logic        slverr;
	} state_t;

endpackage

// *** design/autoneg_page_registers.sv ***
`timescale 1ns/100ps
`include "autoneg_consts.svh"
// Summary of operation
// - advert bit 5, read/write, strap reset value
// - advert selector 4:0 read/write, resets 00001
// - partner register captures received base page
// - partner bit 14 follows received base pages, not next pages
// - partner register read-only, resets to zero
// - expansion bits 15:7 read zero, ignore writes
// - expansion bits 6 and 5 read one
// - parallel detect fault flag sets on fault
// - partner more-pages capable flag sets
// - local more-pages capable reads constant one
// - page received flag, cleared by read
// - partner negotiation capable flag sets
// - next page bit 15 read/write, reset 0
// - next page bit 14 acknowledge, read-only
// - next page bit 13 message flag, reset 1
// - next page bit 12 comply flag, reset 0
// - toggle bit inverts last exchanged toggle
// - next page code read/write, resets null
module autoneg_page_registers #(
	parameter int ADDR_W = 12
) (
	// register bus
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// strap pin, sampled once after reset
	input  wire logic              strap_ten_base,
	// negotiation engine side, all on pclk
	input  wire logic              rx_page_valid,
	input  wire logic [15:0]       rx_page_word,
	input  wire logic              rx_base_page,
	input  wire logic              parallel_fault,
	input  wire logic              partner_an_detect,
	input  wire logic              lcw_sent,
	input  wire logic              lcw_sent_toggle,
	input  wire logic              an_restart,
	// advertised and outgoing words for the engine
	output logic                   advert_ten_base,
	output logic      [4:0]        advert_selector,
	output logic      [15:0]       next_page_word
);

	// elaboration checks: the index decode needs seven address bits,
	// and the bus carries no more than thirty-two
	if (ADDR_W < 7) begin : g_addr_narrow
		$error("ADDR_W must be at least 7");
	end
	if (ADDR_W > 32) begin : g_addr_wide
		$error("ADDR_W must be at most 32");
	end

	autoneg_pkg::state_t s_q;
	autoneg_pkg::state_t s_d;

	logic        setup;
	logic        access;
	logic        hit;
	logic [4:0]  idx;
	logic [15:0] exp_word;
	logic [15:0] np_word;
	logic        rd_done;
	logic        wr_done;
	logic [15:0] adv_word;

	// aligned word index, or all ones when misaligned or at byte address 128 and above
	function automatic logic [4:0] word_index(input logic [ADDR_W-1:0] a);
		logic [4:0] r;
		r = 5'h1F;
		if (a[1:0] == 2'h0 && (a >> 7) == '0) begin
			r = a[6:2];
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [4:0] i);
		return (i == `IDX_LOCAL_ABILITY_ADVERT) || (i == `IDX_PARTNER_BASE_ABILITY)
			|| (i == `IDX_NEGOTIATION_EXPANSION) || (i == `IDX_OUTGOING_NEXT_PAGE);
	endfunction

	// true for the two words that hold software-owned fields
	function automatic logic writable(input logic [4:0] i);
		return (i == `IDX_LOCAL_ABILITY_ADVERT) || (i == `IDX_OUTGOING_NEXT_PAGE);
	endfunction

	// advertisement word; the upper abilities are not stored and read zero
	function automatic logic [15:0] advert_pack(
		input logic       ten,
		input logic [4:0] sel
	);
		logic [15:0] r;
		r               = 16'h0000;
		r[`ADV_TEN_BIT] = ten;
		r[4:0]          = sel;
		return r;
	endfunction

	// expansion word; fixed fields are constants, so no write reaches them
	function automatic logic [15:0] exp_pack(
		input logic pd,
		input logic np_cap,
		input logic rx,
		input logic an_cap
	);
		logic [15:0] r;
		r       = 16'h0000;
		r[15:7] = `EXP_RESERVED;
		r[6]    = `EXP_LOC_SPECIFIED;
		r[5]    = `EXP_LOC_SELECT;
		r[4]    = pd;
		r[3]    = np_cap;
		r[2]    = `EXP_LOCAL_MORE_CAPABLE;
		r[1]    = rx;
		r[0]    = an_cap;
		return r;
	endfunction

	// outgoing next page; acknowledge and toggle belong to the engine
	function automatic logic [15:0] np_pack(
		input logic        more,
		input logic        ack,
		input logic        msg,
		input logic        comply,
		input logic        tog,
		input logic [10:0] code
	);
		logic [15:0] r;
		r                 = 16'h0000;
		r[`NP_MORE_BIT]   = more;
		r[14]             = ack;
		r[`NP_MSG_BIT]    = msg;
		r[`NP_COMPLY_BIT] = comply;
		r[11]             = tog;
		r[10:0]           = code;
		return r;
	endfunction

	// read multiplexer; holes in the map read zero so nothing leaks
	function automatic logic [15:0] read_word(
		input logic [4:0]  i,
		input logic [15:0] adv,
		input logic [15:0] partner,
		input logic [15:0] expn,
		input logic [15:0] np
	);
		logic [15:0] r;
		r = 16'h0000;
		case (i)
			`IDX_LOCAL_ABILITY_ADVERT: begin
				r = adv;
			end
			`IDX_PARTNER_BASE_ABILITY: begin
				r = partner;
			end
			`IDX_NEGOTIATION_EXPANSION: begin
				r = expn;
			end
			`IDX_OUTGOING_NEXT_PAGE: begin
				r = np;
			end
			default: begin
				r = 16'h0000;
			end
		endcase
		return r;
	endfunction

	// strap pin: three stages, captured once stages two and three agree;
	// the settle count keeps a pin that still moves after reset out
	function automatic autoneg_pkg::state_t strap_step(
		input autoneg_pkg::state_t s,
		input logic                pin
	);
		autoneg_pkg::state_t r;
		r            = s;
		r.strap_sync = {s.strap_sync[1:0], pin};
		if (!s.strap_done) begin
			if (s.strap_cnt != `STRAP_SETTLE) begin
				r.strap_cnt = s.strap_cnt + 2'h1;
			end else if (s.strap_sync[1] == s.strap_sync[2]) begin
				r.adv_ten    = s.strap_sync[2];
				r.strap_done = 1'b1;
			end
		end
		return r;
	endfunction

	// software write to one word; only the read/write fields move
	function automatic autoneg_pkg::state_t apply_write(
		input autoneg_pkg::state_t s,
		input logic [4:0]          i,
		input logic [15:0]         d
	);
		autoneg_pkg::state_t r;
		r = s;
		case (i)
			`IDX_LOCAL_ABILITY_ADVERT: begin
				r.adv_ten    = d[`ADV_TEN_BIT];
				r.adv_sel    = d[4:0];
				r.strap_done = 1'b1;  // late strap must not undo software
			end
			`IDX_OUTGOING_NEXT_PAGE: begin
				r.np_more   = d[`NP_MORE_BIT];
				r.np_msg    = d[`NP_MSG_BIT];
				r.np_comply = d[`NP_COMPLY_BIT];
				r.np_code   = d[10:0];
			end
			default: begin
				r = s;  // read-only words ignore writes, with no error
			end
		endcase
		return r;
	endfunction

	// engine side; clears come before sets so a set in the same cycle wins
	function automatic autoneg_pkg::state_t apply_events(
		input autoneg_pkg::state_t s,
		input logic                sent,
		input logic                sent_tog,
		input logic                an_seen,
		input logic                fault,
		input logic                page,
		input logic                base,
		input logic [15:0]         word
	);
		autoneg_pkg::state_t r;
		r = s;
		// our word went out: drop acknowledge, invert its toggle
		if (sent) begin
			r.np_ack    = 1'b0;
			r.np_toggle = ~sent_tog;
		end
		if (an_seen) begin
			r.partner_an_cap = 1'b1;
		end
		if (fault) begin
			r.pd_fault = 1'b1;
		end
		if (page) begin
			r.page_rx = 1'b1;
			r.np_ack  = 1'b1;
			if (base) begin
				// later next pages are not stored anywhere, so base stays
				r.partner_word   = word & `PARTNER_RX_MASK;
				// a base page at all proves the partner negotiates
				r.partner_an_cap = 1'b1;
				if (word[`PAGE_MORE_BIT]) begin
					r.partner_np_cap = 1'b1;
				end
			end
		end
		return r;
	endfunction

	// bus phases; read data is latched in setup so access answers at once,
	// which costs a flop per data bit but keeps the slave at zero waits
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign idx     = word_index(paddr);
	assign hit     = mapped(idx);
	assign rd_done = access & ~pwrite & hit;
	assign wr_done = access & pwrite & hit & writable(idx);

	// read-back words for the bus; only np_word also drives an engine output
	assign adv_word = advert_pack(s_q.adv_ten, s_q.adv_sel);
	assign exp_word = exp_pack(s_q.pd_fault, s_q.partner_np_cap, s_q.page_rx,
		s_q.partner_an_cap);
	assign np_word  = np_pack(s_q.np_more, s_q.np_ack, s_q.np_msg, s_q.np_comply,
		s_q.np_toggle, s_q.np_code);

	// next-state logic for every register of the block
	always_comb begin
		s_d = s_q;

		// strap first, so a software write in the same cycle wins
		s_d = strap_step(s_d, strap_ten_base);

		// restart wipes the fault and partner capability flags, not the partner word
		if (an_restart) begin
			s_d.pd_fault       = 1'b0;
			s_d.partner_np_cap = 1'b0;
			s_d.partner_an_cap = 1'b0;
		end

		// read data and error captured in the setup cycle
		if (setup) begin
			s_d.slverr = ~hit;
			s_d.rdata  = read_word(idx, adv_word, s_q.partner_word, exp_word, np_word);
		end

		// whole-word writes on the access edge; read-only bits ignored
		if (wr_done) begin
			s_d = apply_write(s_d, idx, pwdata[15:0]);
		end

		// page received flag clears on a completed read of expansion
		if (rd_done && idx == `IDX_NEGOTIATION_EXPANSION) begin
			s_d.page_rx = 1'b0;
		end

		// engine events come last so a set beats any clear
		s_d = apply_events(s_d, lcw_sent, lcw_sent_toggle, partner_an_detect,
			parallel_fault, rx_page_valid, rx_base_page, rx_page_word);
	end

	// single state register; asynchronous reset loads constants only,
	// the strap value arrives later through the synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q                <= '0;
			s_q.adv_sel        <= `ADV_SEL_RESET;
			s_q.partner_word   <= `PARTNER_RESET;
			s_q.np_more        <= `NP_MORE_RESET;
			s_q.np_msg         <= `NP_MSG_RESET;
			s_q.np_comply      <= `NP_COMPLY_RESET;
			s_q.np_code        <= `NP_CODE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// zero-wait slave: answer in the first access cycle
	assign pready          = access;
	assign pslverr         = access & s_q.slverr;
	assign prdata          = {16'h0000, s_q.rdata};
	assign advert_ten_base = s_q.adv_ten;
	assign advert_selector = s_q.adv_sel;
	assign next_page_word  = np_word;

endmodule

// *** verification/autoneg_checker.sv ***
`timescale 1ns/100ps
module autoneg_checker #(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              rx_page_valid,
	input wire logic              lcw_sent,
	input wire logic              lcw_sent_toggle,
	input wire logic [4:0]        advert_selector,
	input wire logic [15:0]       next_page_word
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic rd18;
	// completed transfer, and a completed read of the expansion word
	assign acc = psel && penable && pready;
	assign rd18 = acc && !pwrite && paddr == 'h18;
	a_ready_zero: assert property (psel && penable |-> pready)
		else $error("access cycle without ready");
	a_sel_write: assert property (acc && pwrite && paddr == 'h10
		|=> advert_selector == $past(pwdata[4:0]))
		else $error("selector not written");
	a_page_write: assert property (acc && pwrite && paddr == 'h1C
		|=> (next_page_word & 16'hB7FF) == ($past(pwdata[15:0]) & 16'hB7FF))
		else $error("next page fields not written");
	a_ack_set: assert property (rx_page_valid |=> next_page_word[14])
		else $error("acknowledge not set");
	a_toggle_inv: assert property (lcw_sent |=> next_page_word[11] == !$past(lcw_sent_toggle))
		else $error("toggle not inverted");
	a_exp_fixed: assert property (rd18
		|-> prdata[15:5] == 11'h003 && prdata[2])
		else $error("expansion constants wrong");
	a_partner_rsvd: assert property (acc && !pwrite && paddr == 'h14
		|-> !prdata[12] && prdata[31:16] == 16'h0000)
		else $error("partner reserved bit set");
	a_unmapped_err: assert property (acc && paddr >= 'h80
		|-> pslverr && (pwrite || prdata == 32'h0000_0000))
		else $error("unmapped access not refused");
	// a second read with no page in between must see the flag gone
	a_flag_clear: assert property (rd18 && !rx_page_valid
		##1 (!rx_page_valid)[*2] ##1 rd18 |-> !prdata[1])
		else $error("page flag not cleared by read");
endmodule
bind autoneg_page_registers autoneg_checker #(.ADDR_W(ADDR_W)) u_autoneg_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_page_valid(rx_page_valid), .lcw_sent(lcw_sent), .lcw_sent_toggle(lcw_sent_toggle),
	.advert_selector(advert_selector), .next_page_word(next_page_word));

// *** verification/link_partner_model.sv ***
`timescale 1ns/100ps
module link_partner_model (
	input wire logic    pclk,
	output logic        rx_page_valid,
	output logic [15:0] rx_page_word,
	output logic        rx_base_page,
	output logic        lcw_sent,
	output logic        lcw_sent_toggle
);
	// quiet engine at time zero
	initial begin
		rx_page_valid = 1'b0;
		rx_page_word = 16'h0000;
		rx_base_page = 1'b0;
		lcw_sent = 1'b0;
		lcw_sent_toggle = 1'b0;
	end
	// one received word; afterwards the lines show its inverse, not a held copy
	task automatic page(input logic [15:0] w, input logic b);
		@(posedge pclk);
		rx_page_valid <= 1'b1;
		rx_page_word <= w;
		rx_base_page <= b;
		@(posedge pclk);
		rx_page_valid <= 1'b0;
		rx_page_word <= ~w;
		rx_base_page <= ~b;
	endtask
	// one local word exchanged with toggle t
	task automatic sent(input logic t);
		@(posedge pclk);
		lcw_sent <= 1'b1;
		lcw_sent_toggle <= t;
		@(posedge pclk);
		lcw_sent <= 1'b0;
		lcw_sent_toggle <= ~t;
	endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, strap_ten_base;
	logic parallel_fault, partner_an_detect, an_restart, advert_ten_base;
	logic rx_page_valid, rx_base_page, lcw_sent, lcw_sent_toggle;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, seed;
	logic [15:0] rx_page_word, next_page_word, w;
	logic [4:0]  advert_selector;
	int          n_errors, checked, cyc;
	autoneg_page_registers u_autoneg_page_registers (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_ten_base(strap_ten_base),
		.rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word), .rx_base_page(rx_base_page),
		.parallel_fault(parallel_fault), .partner_an_detect(partner_an_detect),
		.lcw_sent(lcw_sent), .lcw_sent_toggle(lcw_sent_toggle), .an_restart(an_restart),
		.advert_ten_base(advert_ten_base), .advert_selector(advert_selector),
		.next_page_word(next_page_word));
	link_partner_model u_link_partner_model (.pclk(pclk), .rx_page_valid(rx_page_valid),
		.rx_page_word(rx_page_word), .rx_base_page(rx_base_page), .lcw_sent(lcw_sent),
		.lcw_sent_toggle(lcw_sent_toggle));
	always #50 pclk = ~pclk;
	// hang guard, far above the hundred or so cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			conclude();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// next page word after a write of w, a last toggle t and acknowledge a
	function automatic logic [31:0] np_exp(input logic [15:0] w, input logic t, a);
		return {16'h0000, (w & 16'hB7FF) | {1'b0, a, 2'b00, ~t, 11'h000}};
	endfunction
	task automatic chk(input string s, input logic [31:0] x, g);
		checked++;
		if (g !== x) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", s, x, g);
		end
	endtask
	// one apb transfer; upper write bits are random, the slave ignores them
	task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {seed[15:0], d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string s);
		apb(1'b0, a, 16'h0000);
		chk(s, x, r);
	endtask
	task automatic pulse(input logic [2:0] v);
		@(posedge pclk);
		{parallel_fault, partner_an_detect, an_restart} <= v;
		@(posedge pclk);
		{parallel_fault, partner_an_detect, an_restart} <= 3'b000;
	endtask
	task automatic conclude();
		$display("checked %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{pclk, presetn, psel, penable, pwrite, strap_ten_base} = 6'b00_0001;
		{parallel_fault, partner_an_detect, an_restart} = 3'b000;
		{paddr, pwdata, seed, n_errors, checked, cyc} = {44'h0, 32'hb596_6f4d, 96'h0};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(12'h010, 32'h0000_0021, "advert reset");
		rd(12'h01C, 32'h0000_2001, "next page reset");
		// writes to read-only places must change nothing
		apb(1'b1, 12'h014, 16'hFFFF);
		apb(1'b1, 12'h018, 16'hFFFF);
		rd(12'h014, 32'h0000_0000, "partner");
		rd(12'h018, 32'h0000_0064, "expansion");
		apb(1'b0, 12'h080, 16'h0000);
		chk("slave error", 32'h0000_0001, {31'h0, e});
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			apb(1'b1, 12'h010, seed[31:16]);
			rd(12'h010, {16'h0000, seed[31:16] & 16'h003F}, "advert");
			chk("advert ten pin", {31'h0, seed[21]}, {31'h0, advert_ten_base});
		end
		pulse(3'b001);
		w = seed[15:0] | 16'h8000;
		u_link_partner_model.page(w, 1'b1);
		rd(12'h014, {16'h0000, w & 16'hEFFF}, "partner word");
		rd(12'h018, 32'h0000_006F, "page flags");
		rd(12'h018, 32'h0000_006D, "flag cleared");
		// a next page must leave the base abilities alone
		u_link_partner_model.page(~w, 1'b0);
		rd(12'h014, {16'h0000, w & 16'hEFFF}, "partner kept");
		pulse(3'b110);
		rd(12'h018, 32'h0000_007F, "faults");
		pulse(3'b001);
		rd(12'h018, 32'h0000_0064, "restart");
		for (int t = 0; t < 2; t++) begin
			seed = xs(seed);
			apb(1'b1, 12'h01C, seed[15:0]);
			u_link_partner_model.sent(t[0]);
			rd(12'h01C, np_exp(seed[15:0], t[0], 1'b0), "page sent");
			u_link_partner_model.page(seed[15:0], 1'b0);
			rd(12'h01C, np_exp(seed[15:0], t[0], 1'b1), "page ack");
			chk("page pins", np_exp(seed[15:0], t[0], 1'b1), {16'h0000, next_page_word});
		end
		conclude();
	end
endmodule
